// file: drsr_pkg.sv
//
// Purpose: Shared constants for the dual-rail sequencer and reset block
// Assumes: 125 MHz pclk
// Notes:   Register offsets are byte addresses on APB
//
package drsr_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_MHZ         = 125;
  localparam int unsigned RELEASE_DLY_MS  = 120;
  localparam int unsigned RELEASE_CYCLES  = RELEASE_DLY_MS * 1000 * CLK_MHZ;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_IRQ_ST = 12'h008;
  localparam logic [11:0] OFS_IRQ_MS = 12'h00C;

  // Status and interrupt bit positions
  localparam int unsigned BIT_R1_ON  = 0;
  localparam int unsigned BIT_R2_ON  = 1;
  localparam int unsigned BIT_GOOD1  = 2;
  localparam int unsigned BIT_RST    = 3;
  localparam int unsigned BIT_R2_OK  = 4;
  localparam int unsigned NUM_EVT    = 4;

  // Event bits: reset released, reset asserted, rail1 fault, rail2 fault
  localparam int unsigned EVT_REL    = 0;
  localparam int unsigned EVT_ASSERT = 1;
  localparam int unsigned EVT_F1     = 2;
  localparam int unsigned EVT_F2     = 3;

  localparam logic [31:0] CTRL_RST_VAL = 32'h0000_0000;
  localparam logic [31:0] MASK_RST_VAL = 32'h0000_0000;

  // ************************************************************
  // Sequencer states
  // ************************************************************
  typedef enum logic [2:0] {
    DRSR_OFF,
    DRSR_FIRST,
    DRSR_BOTH
  } drsr_state_e;

endpackage : drsr_pkg

// file: drsr_top.sv
//
// Purpose: Dual-rail power-up sequencer with delayed system reset
// Assumes: Comparator inputs and pins are asynchronous to pclk
// Notes:   Control and status also visible over APB
//
// Overview of operation
// - While enable_n is high, both rails off, good and reset outputs low.
// - Order select high: enable low switches rail 2 on first.
// - Second rail switches on only after first rail passes 83 percent.
// - Order select low: rail 1 first, then rail 2.
// - Rail1 good follows rail 1 at or above 95 percent.
// - Both rails good and both manual resets high releases reset after 120 ms.
// - Manual reset A low asserts reset at once, rails stay enabled.
// - Manual reset A returning high restarts the full release delay.
// - Rail 1 fault drops good, which via board tie asserts reset.
// - With order select high, rail 1 fault keeps rail 2 enabled.
// - Rail 2 below 95 percent drives reset low immediately.
// - Either manual reset low forces reset low regardless of rails.
//
`timescale 1ns/1ps

module drsr_top
  import drsr_pkg::*;
#(
  parameter int unsigned RELEASE_CNT = RELEASE_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Board pins
  input  wire logic        enable_n,
  input  wire logic        order_select,
  input  wire logic        manual_reset_a_n,
  input  wire logic        manual_reset_b_n,
  // Rail comparators
  input  wire logic        rail1_above83,
  input  wire logic        rail1_above95,
  input  wire logic        rail2_above83,
  input  wire logic        rail2_above95,
  // Rail enables and supervisor outputs
  output logic             rail1_output,
  output logic             rail2_output,
  output logic             rail1_good,
  output logic             sys_reset_n,
  output logic             irq
);

  // Elaboration check on the release count
  if (RELEASE_CNT < 2) begin : g_bad_cnt
    $error("RELEASE_CNT too small");
  end

  localparam int unsigned CW = $clog2(RELEASE_CNT + 1);
  localparam int unsigned NSYNC = 8;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic [NSYNC-1:0] s3_r;
  logic [NSYNC-1:0] clean_r;

  assign raw_in = {rail2_above95, rail2_above83, rail1_above95, rail1_above83,
                   manual_reset_b_n, manual_reset_a_n, order_select, enable_n};

  // Three-stage sync, change accepted when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r    <= '0;
      s2_r    <= '0;
      s3_r    <= '0;
      clean_r <= 8'h01;
    end else begin
      s1_r <= raw_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < NSYNC; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          clean_r[i] <= s3_r[i];
        end
      end
    end
  end

  logic en_off;
  logic sel_hi;
  logic mra_ok;
  logic mrb_ok;
  logic r1_83;
  logic r1_95;
  logic r2_83;
  logic r2_95;

  assign en_off = clean_r[0];
  assign sel_hi = clean_r[1];
  assign mra_ok = clean_r[2];
  assign mrb_ok = clean_r[3];
  assign r1_83  = clean_r[4];
  assign r1_95  = clean_r[5];
  assign r2_83  = clean_r[6];
  assign r2_95  = clean_r[7];

  // ************************************************************
  // Software control
  // ************************************************************
  logic [31:0] ctrl_r;
  logic        sw_off;
  assign sw_off = ctrl_r[0];

  // ************************************************************
  // Sequencer
  // ************************************************************
  drsr_state_e state_r;
  logic        order_r;
  logic        shut;

  assign shut = en_off | sw_off;

  // Power-up order latched at enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= DRSR_OFF;
      order_r <= 1'b0;
    end else if (shut) begin
      state_r <= DRSR_OFF;
    end else begin
      unique case (state_r)
        DRSR_OFF: begin
          order_r <= sel_hi;
          state_r <= DRSR_FIRST;
        end
        DRSR_FIRST: begin
          if (order_r ? r2_83 : r1_83) begin
            state_r <= DRSR_BOTH;
          end
        end
        DRSR_BOTH: begin
          state_r <= DRSR_BOTH;
        end
        default: state_r <= DRSR_OFF;
      endcase
    end
  end

  // Rail enables from state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rail1_output <= 1'b0;
      rail2_output <= 1'b0;
    end else begin
      rail1_output <= !shut && (state_r == DRSR_BOTH ||
                      (state_r == DRSR_FIRST && !order_r));
      rail2_output <= !shut && (state_r == DRSR_BOTH ||
                      (state_r == DRSR_FIRST && order_r));
    end
  end

  // Rail 1 good output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rail1_good <= 1'b0;
    end else begin
      rail1_good <= !shut && r1_95;
    end
  end

  // ************************************************************
  // Reset release delay
  // ************************************************************
  logic          rel_ok;
  logic [CW-1:0] cnt_r;

  // Manual resets gate release independently of rails
  assign rel_ok = !shut && r1_95 && r2_95 && mra_ok && mrb_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r       <= '0;
      sys_reset_n <= 1'b0;
    end else if (!rel_ok) begin
      cnt_r       <= '0;
      sys_reset_n <= 1'b0;
    end else if (cnt_r == CW'(RELEASE_CNT - 1)) begin
      sys_reset_n <= 1'b1;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  logic [NUM_EVT-1:0] evt;
  logic [NUM_EVT-1:0] ist_r;
  logic [NUM_EVT-1:0] imask_r;
  logic               rst_d_r;
  logic               good_d_r;
  logic               r2_d_r;
  logic               wr;
  logic [NUM_EVT-1:0] w1c;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_d_r  <= 1'b0;
      good_d_r <= 1'b0;
      r2_d_r   <= 1'b0;
    end else begin
      rst_d_r  <= sys_reset_n;
      good_d_r <= rail1_good;
      r2_d_r   <= r2_95;
    end
  end

  assign evt[EVT_REL]    = sys_reset_n & ~rst_d_r;
  assign evt[EVT_ASSERT] = ~sys_reset_n & rst_d_r;
  assign evt[EVT_F1]     = ~rail1_good & good_d_r & ~shut;
  assign evt[EVT_F2]     = ~r2_95 & r2_d_r & ~shut;

  assign wr  = psel & penable & pwrite;
  assign w1c = (wr && paddr == OFS_IRQ_ST) ? pwdata[NUM_EVT-1:0] : '0;

  // Sticky status, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= '0;
    end else begin
      ist_r <= (ist_r & ~w1c) | evt;
    end
  end

  assign irq = |(ist_r & imask_r);

  // ************************************************************
  // APB registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= CTRL_RST_VAL;
      imask_r <= MASK_RST_VAL[NUM_EVT-1:0];
    end else if (wr) begin
      if (paddr == OFS_CTRL) ctrl_r <= {31'h0, pwdata[0]};
      if (paddr == OFS_IRQ_MS) imask_r <= pwdata[NUM_EVT-1:0];
    end
  end

  logic        known;
  logic [31:0] rd;

  always_comb begin
    known = 1'b1;
    rd    = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL:   rd = ctrl_r;
      OFS_STATUS: begin
        rd[BIT_R1_ON] = rail1_output;
        rd[BIT_R2_ON] = rail2_output;
        rd[BIT_GOOD1] = rail1_good;
        rd[BIT_RST]   = sys_reset_n;
        rd[BIT_R2_OK] = r2_95;
      end
      OFS_IRQ_ST: rd[NUM_EVT-1:0] = ist_r;
      OFS_IRQ_MS: rd[NUM_EVT-1:0] = imask_r;
      default:    known = 1'b0;
    endcase
  end

  // Read data registered in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~known;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_off_rails: assert property (@(posedge pclk) disable iff (!presetn)
    shut |=> !rail1_output && !rail2_output && !sys_reset_n && !rail1_good)
    else $error("outputs active while disabled");

  a_seq_hi: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == DRSR_FIRST && order_r && !shut) |=> rail2_output && !rail1_output)
    else $error("wrong first rail with order high");

  a_seq_lo: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == DRSR_FIRST && !order_r && !shut) |=> rail1_output && !rail2_output)
    else $error("wrong first rail with order low");

  a_second_gate: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_r == DRSR_BOTH) |-> $past(order_r ? r2_83 : r1_83))
    else $error("second rail before 83 percent");

  a_good_track: assert property (@(posedge pclk) disable iff (!presetn)
    !r1_95 |=> !rail1_good)
    else $error("good high while rail 1 low");

  a_mr_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (!mra_ok || !mrb_ok) |=> !sys_reset_n)
    else $error("reset released during manual reset");

  a_r2_fault: assert property (@(posedge pclk) disable iff (!presetn)
    !r2_95 |=> !sys_reset_n)
    else $error("reset high with rail 2 low");

  a_rail2_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (rail2_output && !shut && state_r == DRSR_BOTH) |=> rail2_output || shut)
    else $error("rail 2 dropped without disable");

  a_delay_full: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(sys_reset_n) |-> cnt_r == CW'(RELEASE_CNT - 1))
    else $error("reset released before full delay");

  c_release: cover property (@(posedge pclk) disable iff (!presetn) $rose(sys_reset_n));
  c_mr_toggle: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(mra_ok) && rail1_output && rail2_output);
  c_r1_fault: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(rail1_good) && rail2_output);
  c_order_hi: cover property (@(posedge pclk) disable iff (!presetn)
    rail2_output && !rail1_output);

endmodule : drsr_top

// file: drsr_rail_model.sv
// Purpose: Rail and comparator model for the sequencer bench
// Assumes: Each rail ramps over RAMP cycles once enabled
// Notes:   A fault input holds its rail below the upper threshold
`timescale 1ns/1ps

module drsr_rail_model #(
  parameter int RAMP = 6
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Rail enables and injected faults
  input  wire logic rail1_output,
  input  wire logic rail2_output,
  input  wire logic fault1,
  input  wire logic fault2,
  // Comparator levels
  output logic      rail1_above83,
  output logic      rail1_above95,
  output logic      rail2_above83,
  output logic      rail2_above95
);
  int c1;
  int c2;

  // ******
  // Ramps
  // ******
  // Rail level climbs while enabled, collapses when switched off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1 <= 0;
      c2 <= 0;
    end else begin
      c1 <= rail1_output ? ((c1 < RAMP) ? c1 + 1 : c1) : 0;
      c2 <= rail2_output ? ((c2 < RAMP) ? c2 + 1 : c2) : 0;
    end
  end

  // Thresholds from the level
  assign rail1_above83 = (c1 >= RAMP / 2);
  assign rail1_above95 = (c1 >= RAMP) && !fault1;
  assign rail2_above83 = (c2 >= RAMP / 2);
  assign rail2_above95 = (c2 >= RAMP) && !fault2;
endmodule : drsr_rail_model

// file: tb_drsr_top.sv
// Purpose: Self-checking bench for the dual-rail sequencer
// Assumes: Short release count, board ties rail1 good to reset input B
// Notes:   Order and pulse widths partly random, seed fixed
`timescale 1ns/1ps

module tb_drsr_top;
  import drsr_pkg::*;
  localparam int RC = 20;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic        pready, pslverr, e, irq, manual_reset_b_n;
  logic        enable_n = 1, order_select = 1, manual_reset_a_n = 1;
  logic        fault1 = 0, fault2 = 0, r1_83, r1_95, r2_83, r2_95;
  logic        rail1_output, rail2_output, rail1_good, sys_reset_n;
  logic        first_on, second_on, first_83;
  int          mismatches = 0, n_checks = 0, n, it;

  // Clock and board wiring
  always #4 pclk = ~pclk;
  assign manual_reset_b_n = rail1_good;
  assign first_on  = order_select ? rail2_output : rail1_output;
  assign second_on = order_select ? rail1_output : rail2_output;
  assign first_83  = order_select ? r2_83 : r1_83;

  drsr_top #(.RELEASE_CNT(RC)) drsr_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .enable_n(enable_n),
    .order_select(order_select), .manual_reset_a_n(manual_reset_a_n),
    .manual_reset_b_n(manual_reset_b_n), .rail1_above83(r1_83), .rail1_above95(r1_95),
    .rail2_above83(r2_83), .rail2_above95(r2_95), .rail1_output(rail1_output),
    .rail2_output(rail2_output), .rail1_good(rail1_good), .sys_reset_n(sys_reset_n),
    .irq(irq));
  drsr_rail_model drsr_rail_model_inst (.pclk(pclk), .presetn(presetn),
    .rail1_output(rail1_output), .rail2_output(rail2_output), .fault1(fault1),
    .fault2(fault2), .rail1_above83(r1_83), .rail1_above95(r1_95),
    .rail2_above83(r2_83), .rail2_above95(r2_95));

  // ******
  // Helpers
  // ******
  function automatic logic in_win(input int c);
    return (c >= RC) && (c <= RC + 12);
  endfunction : in_win

  function automatic logic [31:0] exp_irq(input int i);
    return 32'h0000_0003 | ((i == 1) ? 32'h0000_0004 : (i == 2) ? 32'h0000_0008 : 32'h0);
  endfunction : exp_irq

  task automatic cmp_bit(input logic a, input logic x);
    n_checks++;
    if (a !== x) begin
      mismatches++;
      $display("Error at %0t: bit %b, expected %b", $time, a, x);
    end
  endtask : cmp_bit

  task automatic cmp_word(input logic [31:0] a, input logic [31:0] x);
    n_checks++;
    if (a !== x) begin
      mismatches++;
      $display("Error at %0t: word %h, expected %h", $time, a, x);
    end
  endtask : cmp_word

  // One APB transfer, result left in q and e
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Counts negedges until reset output releases
  task automatic wait_release;
    for (n = 0; n < RC + 60 && sys_reset_n !== 1'b1; n++) @(negedge pclk);
  endtask : wait_release

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // Watchdog
  initial begin
    #(8 * 40000);
    mismatches++;
    close_out();
  end

  // ******
  // Main sequence
  // ******
  initial begin
    void'($urandom(53));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(negedge pclk);
    cmp_bit(rail1_output | rail2_output | rail1_good | sys_reset_n, 1'b0);
    apb(1'b0, 12'h010, 32'h0);
    cmp_word({31'h0, e} | q, 32'h0000_0001);
    apb(1'b1, OFS_IRQ_MS, 32'h0000_000F);
    for (it = 0; it < 4; it++) begin
      apb(1'b1, OFS_IRQ_ST, 32'h0000_000F);
      @(posedge pclk);
      order_select <= (it == 2) ? 1'b0 : (it == 3) ? 1'($urandom_range(1, 0)) : 1'b1;
      enable_n <= 1'b0;
      for (n = 0; n < 200 && first_on !== 1'b1; n++) @(negedge pclk);
      cmp_bit(second_on, 1'b0);
      for (n = 0; n < 200 && second_on !== 1'b1; n++) @(negedge pclk);
      cmp_bit(first_83, 1'b1);
      for (n = 0; n < 200 && !(r1_95 && r2_95); n++) @(negedge pclk);
      wait_release();
      cmp_bit(in_win(n), 1'b1);
      apb(1'b0, OFS_STATUS, 32'h0);
      cmp_word(q, 32'h0000_001F);
      @(posedge pclk);
      if (it == 1) fault1 <= 1'b1;
      else if (it == 2) fault2 <= 1'b1;
      else manual_reset_a_n <= 1'b0;
      repeat (8) @(negedge pclk);
      cmp_bit(sys_reset_n, 1'b0);
      cmp_bit(rail1_good, it != 1);
      cmp_bit(rail1_output & rail2_output, 1'b1);
      repeat ($urandom_range(8, 1)) @(posedge pclk);
      fault1 <= 1'b0;
      fault2 <= 1'b0;
      manual_reset_a_n <= 1'b1;
      if (it == 3) begin
        repeat (RC / 2) @(posedge pclk);
        manual_reset_a_n <= 1'b0;
        repeat (3) @(posedge pclk);
        manual_reset_a_n <= 1'b1;
      end
      wait_release();
      if (it != 1) cmp_bit(in_win(n), 1'b1);
      cmp_bit(sys_reset_n, 1'b1);
      apb(1'b0, OFS_IRQ_ST, 32'h0);
      cmp_word(q, exp_irq(it));
      apb(1'b1, OFS_IRQ_MS, 32'h0);
      @(negedge pclk);
      cmp_bit(irq, 1'b0);
      apb(1'b1, OFS_IRQ_MS, 32'h0000_000F);
      @(negedge pclk);
      cmp_bit(irq, 1'b1);
      apb(1'b1, OFS_IRQ_ST, 32'h0000_000F);
      apb(1'b0, OFS_IRQ_ST, 32'h0);
      cmp_word(q, 32'h0);
      @(posedge pclk);
      enable_n <= 1'b1;
      repeat (8) @(negedge pclk);
      cmp_bit(rail1_output | rail2_output | rail1_good | sys_reset_n, 1'b0);
    end
    // Software off bit while running
    @(posedge pclk);
    enable_n <= 1'b0;
    for (n = 0; n < 400 && sys_reset_n !== 1'b1; n++) @(negedge pclk);
    cmp_bit(sys_reset_n, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    repeat (2) @(negedge pclk);
    cmp_bit(rail1_output | rail2_output | rail1_good | sys_reset_n, 1'b0);
    apb(1'b0, OFS_CTRL, 32'h0);
    cmp_word(q, 32'h0000_0001);
    close_out();
  end
endmodule : tb_drsr_top
